// file: include/paged_serial_map.svh
// offsets, field positions, reset values and counts of the paged serial port
`ifndef PAGED_SERIAL_MAP_SVH
`define PAGED_SERIAL_MAP_SVH

`define CMD_DIR_BIT 15
`define CMD_PAGE_HI 14
`define CMD_PAGE_LO 11
`define CMD_INDEX_HI 10
`define CMD_INDEX_LO 5

`define PAGE_DATA 4'h0
`define PAGE_CTRL 4'h1

`define IDX_LAST 6'h1F
`define IDX_RESULT_LAST 6'h0A
`define IDX_DAC 6'h0B
`define IDX_ZERO 6'h10
`define IDX_CONV_CTRL 6'h00
`define IDX_KEY_CTRL 6'h01
`define IDX_DAC_CTRL 6'h02
`define IDX_REF_CTRL 6'h03
`define IDX_SWRST_CTRL 6'h04
`define IDX_TIMING_CFG 6'h05
`define IDX_KEY_MASK 6'h10
`define SLOT_KEY_MASK 3'h6

`define RESULT_RESET 16'h0000
`define DAC_RESET 8'h7F
`define CTRL_RESET 16'h0000
`define WORD_ONES 16'hFFFF
`define WORD_ZERO 16'h0000
`define WORD_LAST_BIT 4'hF

`endif

// file: include/paged_serial_pkg.sv
// types of the paged serial port
package paged_serial_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_READ = 2'b10,
        ST_WRITE = 2'b11
    } phase_t;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] mosi_sync;
        logic [2:0] ss_sync;
        phase_t phase;
        logic [3:0] bit_cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [3:0] page;
        logic [5:0] ptr;
        logic past_end;
        logic miso;
        logic miso_oe_n;
        logic [10:0][15:0] results;
        logic [7:0] dac;
        logic [6:0][15:0] ctrl;
    } port_state_t;

endpackage

// file: design/paged_serial_register_port.sv
// serial slave port giving a host access to two pages of 16-bit registers
// Behaviour
// [R01] clock idles low, data launched first edge
// [R02] commands only honoured after select falls
// [R03] 16-bit command word precedes data words
// [R04] command bit 15: one reads, zero writes
// [R05] bits 14..11 select page 0 or 1
// [R06] bits 10..5 give starting register index
// [R07] command bits 4..0 are ignored
// [R08] 8000 hex reads page 0 from register 0
// [R09] 0800 hex writes page 1 from register 0
// [R10] pointer steps by one after each word
// [R11] reads past page end return FFFF
// [R12] MISO shifts out while MOSI shifts in
// [R13] host makes the clock and starts transfers
// [R14] both sides drive data from first edge
// [R15] registers are 16 bits, data and control pages
// [R16] reserved data words read FFFF, zero word 0000
// [R17] select rising aborts and awaits new command
// [R18] complete write word stored before pointer advances
`timescale 1ns/1ps
`include "paged_serial_map.svh"

module paged_serial_register_port (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    output logic miso_oe_n,
    input wire logic meas_wr_en,
    input wire logic [3:0] meas_wr_index,
    input wire logic [15:0] meas_wr_data,
    output logic [7:0] contrast_output_value,
    output logic [15:0] converter_control,
    output logic [15:0] keypad_scan_control,
    output logic [15:0] contrast_output_control,
    output logic [15:0] voltage_reference_control,
    output logic [15:0] software_reset_control,
    output logic [15:0] timing_configuration,
    output logic [15:0] keypad_key_mask
);

    localparam paged_serial_pkg::port_state_t RESET_STATE = '{
        sclk_sync: 3'h0,
        mosi_sync: 2'h0,
        ss_sync: 3'h0,
        phase: paged_serial_pkg::ST_IDLE,
        bit_cnt: 4'h0,
        rx: `WORD_ZERO,
        tx: `WORD_ZERO,
        page: `PAGE_DATA,
        ptr: 6'h00,
        past_end: 1'b0,
        miso: 1'b0,
        miso_oe_n: 1'b1,
        results: {11{`RESULT_RESET}},
        dac: `DAC_RESET,
        ctrl: {7{`CTRL_RESET}}
    };

    paged_serial_pkg::port_state_t q;
    paged_serial_pkg::port_state_t next_q;

    logic sclk_rise;
    logic sclk_fall;
    logic ss_rise;
    logic ss_fall;
    logic in_frame;
    logic word_end;
    logic [15:0] rx_in;
    logic [3:0] cmd_page;
    logic [5:0] cmd_index;

    // word seen at a page and index; unmapped places read all ones
    function automatic logic [15:0] read_word(
        input paged_serial_pkg::port_state_t s,
        input logic [3:0] pg,
        input logic [5:0] idx
    );
        logic [15:0] rd;
        rd = `WORD_ONES;
        if (pg == `PAGE_DATA)
        begin
            if (idx <= `IDX_RESULT_LAST)
            begin
                rd = s.results[idx[3:0]];
            end
            else if (idx == `IDX_DAC)
            begin
                rd = {8'h00, s.dac};
            end
            else if (idx == `IDX_ZERO)
            begin
                rd = `WORD_ZERO; // see [R16]
            end
        end
        else if (pg == `PAGE_CTRL)
        begin
            if (idx <= `IDX_TIMING_CFG)
            begin
                rd = s.ctrl[idx[2:0]];
            end
            else if (idx == `IDX_KEY_MASK)
            begin
                rd = s.ctrl[`SLOT_KEY_MASK];
            end
        end
        return rd;
    endfunction

    // edges come from the second and third synchroniser stages only
    assign sclk_rise = q.sclk_sync[1] & ~q.sclk_sync[2];
    assign sclk_fall = ~q.sclk_sync[1] & q.sclk_sync[2];
    assign ss_rise = q.ss_sync[1] & ~q.ss_sync[2];
    assign ss_fall = ~q.ss_sync[1] & q.ss_sync[2];
    assign in_frame = ~ss_rise & ~ss_fall & (q.phase != paged_serial_pkg::ST_IDLE);
    assign word_end = ce & in_frame & sclk_fall & (q.bit_cnt == `WORD_LAST_BIT);
    assign rx_in = {q.rx[14:0], q.mosi_sync[1]};
    assign cmd_page = rx_in[`CMD_PAGE_HI:`CMD_PAGE_LO]; // see [R05]
    // low five command bits are never looked at
    assign cmd_index = rx_in[`CMD_INDEX_HI:`CMD_INDEX_LO]; // see [R06] see [R07]

    always_comb
    begin
        next_q = q;
        next_q.sclk_sync = {q.sclk_sync[1:0], sclk};
        next_q.mosi_sync = {q.mosi_sync[0], mosi};
        next_q.ss_sync = {q.ss_sync[1:0], ss_n};
        if (meas_wr_en && ({2'b00, meas_wr_index} <= `IDX_RESULT_LAST))
        begin
            next_q.results[meas_wr_index] = meas_wr_data;
        end
        if (ss_rise)
        begin
            next_q.phase = paged_serial_pkg::ST_IDLE; // see [R17]
            next_q.bit_cnt = 4'h0;
            next_q.miso = 1'b0;
            next_q.miso_oe_n = 1'b1;
        end
        else if (ss_fall)
        begin
            next_q.phase = paged_serial_pkg::ST_CMD; // see [R02] see [R03]
            next_q.bit_cnt = 4'h0;
            next_q.tx = `WORD_ZERO;
            next_q.miso = 1'b0;
            next_q.miso_oe_n = 1'b0;
        end
        else if (q.phase != paged_serial_pkg::ST_IDLE)
        begin
            if (sclk_rise)
            begin
                // launch on the leading edge, host samples on the trailing one
                next_q.miso = q.tx[15]; // see [R01] see [R12] see [R14]
                next_q.tx = {q.tx[14:0], 1'b0};
            end
            if (sclk_fall)
            begin
                next_q.rx = rx_in; // see [R12]
                next_q.bit_cnt = 4'(q.bit_cnt + 4'h1);
            end
            if (word_end)
            begin
                case (q.phase)
                    paged_serial_pkg::ST_CMD:
                    begin
                        next_q.page = cmd_page;
                        next_q.past_end = 1'b0;
                        if (rx_in[`CMD_DIR_BIT])
                        begin
                            next_q.phase = paged_serial_pkg::ST_READ; // see [R04] see [R08]
                            next_q.tx = read_word(q, cmd_page, cmd_index);
                            if (cmd_index == `IDX_LAST)
                            begin
                                next_q.past_end = 1'b1;
                            end
                            else
                            begin
                                next_q.ptr = 6'(cmd_index + 6'h01);
                            end
                        end
                        else
                        begin
                            next_q.phase = paged_serial_pkg::ST_WRITE; // see [R04] see [R09]
                            next_q.ptr = cmd_index;
                        end
                    end
                    paged_serial_pkg::ST_READ:
                    begin
                        if (q.past_end)
                        begin
                            next_q.tx = `WORD_ONES; // see [R11]
                        end
                        else
                        begin
                            next_q.tx = read_word(q, q.page, q.ptr); // see [R15] see [R16]
                            if (q.ptr == `IDX_LAST)
                            begin
                                next_q.past_end = 1'b1;
                            end
                            else
                            begin
                                next_q.ptr = 6'(q.ptr + 6'h01); // see [R10]
                            end
                        end
                    end
                    paged_serial_pkg::ST_WRITE:
                    begin
                        if (!q.past_end)
                        begin
                            if (q.page == `PAGE_DATA && q.ptr == `IDX_DAC)
                            begin
                                next_q.dac = rx_in[7:0]; // see [R18]
                            end
                            else if (q.page == `PAGE_CTRL && q.ptr <= `IDX_TIMING_CFG)
                            begin
                                next_q.ctrl[q.ptr[2:0]] = rx_in; // see [R18]
                            end
                            else if (q.page == `PAGE_CTRL && q.ptr == `IDX_KEY_MASK)
                            begin
                                next_q.ctrl[`SLOT_KEY_MASK] = rx_in; // see [R18]
                            end
                            if (q.ptr == `IDX_LAST)
                            begin
                                next_q.past_end = 1'b1;
                            end
                            else
                            begin
                                next_q.ptr = 6'(q.ptr + 6'h01); // see [R10]
                            end
                        end
                    end
                    default:
                    begin
                        next_q.phase = paged_serial_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q <= RESET_STATE;
        end
        else if (ce)
        begin
            q <= next_q;
        end
    end

    assign miso = q.miso;
    assign miso_oe_n = q.miso_oe_n;
    assign contrast_output_value = q.dac;
    assign converter_control = q.ctrl[`IDX_CONV_CTRL];
    assign keypad_scan_control = q.ctrl[`IDX_KEY_CTRL];
    assign contrast_output_control = q.ctrl[`IDX_DAC_CTRL];
    assign voltage_reference_control = q.ctrl[`IDX_REF_CTRL];
    assign software_reset_control = q.ctrl[`IDX_SWRST_CTRL];
    assign timing_configuration = q.ctrl[`IDX_TIMING_CFG];
    assign keypad_key_mask = q.ctrl[`SLOT_KEY_MASK];

    // checks tie each decoded effect to the word that caused it

    no_frame_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R02]
        (q.phase == paged_serial_pkg::ST_IDLE && !ss_fall) |=> $stable(q.ctrl))
        else $error("control page changed outside a frame");

    direction_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R04]
        (word_end && q.phase == paged_serial_pkg::ST_CMD) |=>
        (q.phase == ($past(rx_in[15]) ? paged_serial_pkg::ST_READ
                                      : paged_serial_pkg::ST_WRITE)))
        else $error("command direction decoded wrongly");

    page_decode_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R05]
        (word_end && q.phase == paged_serial_pkg::ST_CMD) |=>
        (q.page == $past(rx_in[14:11])))
        else $error("page select decoded wrongly");

    start_index_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R06]
        (word_end && q.phase == paged_serial_pkg::ST_CMD && !rx_in[15]) |=>
        (q.ptr == $past(rx_in[10:5])))
        else $error("write pointer not loaded from index");

    read_load_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R08]
        (word_end && q.phase == paged_serial_pkg::ST_CMD && rx_in[15]) |=>
        (q.tx == read_word($past(q), $past(rx_in[14:11]), $past(rx_in[10:5]))))
        else $error("first read word not fetched from index");

    step_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R10]
        (word_end && q.phase != paged_serial_pkg::ST_CMD && !q.past_end
            && q.ptr != `IDX_LAST) |=> (q.ptr == 6'($past(q.ptr) + 6'h01)))
        else $error("pointer did not step after a word");

    past_end_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R11]
        (word_end && q.phase == paged_serial_pkg::ST_READ && q.past_end) |=>
        (q.tx == `WORD_ONES))
        else $error("read past page end not all ones");

    shift_out_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R12]
        (ce && in_frame && sclk_rise) |=> (miso == $past(q.tx[15])) ##1 $stable(miso))
        else $error("miso not launched on leading edge");

    abort_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R17]
        (ce && ss_rise) |=> (q.phase == paged_serial_pkg::ST_IDLE && q.bit_cnt == 4'h0
            && miso_oe_n))
        else $error("select rise did not abort the word");

    store_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R18]
        (word_end && q.phase == paged_serial_pkg::ST_WRITE && !q.past_end
            && q.page == `PAGE_CTRL && q.ptr <= `IDX_TIMING_CFG) |=>
        (read_word(q, `PAGE_CTRL, $past(q.ptr)) == $past(rx_in)))
        else $error("write word not stored at pointer");

    frame_open_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R02]
        (ce && ss_fall) |=> (q.phase == paged_serial_pkg::ST_CMD && q.bit_cnt == 4'h0
            && !miso_oe_n))
        else $error("select fall did not open a command");

    idle_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R02]
        (ce && q.phase == paged_serial_pkg::ST_IDLE && !ss_fall) |=>
        (q.phase == paged_serial_pkg::ST_IDLE))
        else $error("frame opened without select fall");

    bit_count_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R03]
        (ce && in_frame && sclk_fall) |=> (q.bit_cnt == 4'($past(q.bit_cnt) + 4'h1)))
        else $error("bit count did not step on a trailing edge");

    shift_in_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R12]
        (ce && in_frame && sclk_fall) |=> (q.rx == $past(rx_in)))
        else $error("mosi bit not captured on trailing edge");

    idle_off_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R17]
        (q.phase == paged_serial_pkg::ST_IDLE) |-> miso_oe_n)
        else $error("miso driven outside a frame");

    page_end_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R10]
        (word_end && q.phase != paged_serial_pkg::ST_CMD && !q.past_end
            && q.ptr == `IDX_LAST) |=> (q.past_end && q.ptr == `IDX_LAST))
        else $error("pointer did not stop at page end");

    gap_ones_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R16]
        (word_end && q.phase == paged_serial_pkg::ST_READ && !q.past_end
            && q.page == `PAGE_DATA && q.ptr > `IDX_DAC && q.ptr < `IDX_ZERO) |=>
        (q.tx == `WORD_ONES))
        else $error("reserved data word not all ones");

    zero_word_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R16]
        (word_end && q.phase == paged_serial_pkg::ST_READ && !q.past_end
            && q.page == `PAGE_DATA && q.ptr == `IDX_ZERO) |=>
        (q.tx == `WORD_ZERO))
        else $error("zero word not read as zero");

    bad_page_read_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R05]
        (word_end && q.phase == paged_serial_pkg::ST_CMD && rx_in[`CMD_DIR_BIT]
            && cmd_page != `PAGE_DATA && cmd_page != `PAGE_CTRL) |=> (q.tx == `WORD_ONES))
        else $error("reserved page read not all ones");

    bad_page_write_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R05]
        (word_end && q.phase == paged_serial_pkg::ST_WRITE && q.page != `PAGE_DATA
            && q.page != `PAGE_CTRL) |=> ($stable(q.ctrl) && $stable(q.dac)))
        else $error("reserved page write changed a register");

    dac_store_a: assert property (@(posedge clk_sys) disable iff (srst) // see [R18]
        (word_end && q.phase == paged_serial_pkg::ST_WRITE && !q.past_end
            && q.page == `PAGE_DATA && q.ptr == `IDX_DAC) |=> (q.dac == $past(rx_in[7:0])))
        else $error("contrast word not stored");

    clock_freeze_a: assert property (@(posedge clk_sys) disable iff (srst)
        (!ce) |=> $stable(q))
        else $error("state moved while clock enable low");

endmodule

// file: verif/spi_host_model.sv
// host master model for the paged serial port
`timescale 1ns/1ps

module spi_host_model (
    input wire logic clk_sys,
    output logic sclk,
    output logic mosi,
    output logic ss_n,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end

    // select moves only while the clock idles; a released mosi is scrambled
    task automatic sel(input logic on);
        repeat (8) @(posedge clk_sys);
        ss_n <= ~on;
        mosi <= ~mosi;
        repeat (8) @(posedge clk_sys);
    endtask

    // launch on the rising edge, capture on the falling edge, msb first
    task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        for (int i = 15; i > 15 - n; i--)
        begin
            sclk <= 1'b1;
            mosi <= w[i];
            repeat (8) @(posedge clk_sys);
            sclk <= 1'b0;
            r = {r[14:0], miso};
            repeat (8) @(posedge clk_sys);
        end
    endtask
endmodule

// file: verif/tb_paged_serial_register_port.sv
// self-checking bench of the paged serial register port
`timescale 1ns/1ps

module tb_paged_serial_register_port;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sclk;
    logic mosi;
    logic ss_n;
    logic miso;
    logic miso_oe_n;
    logic ce = 1'b1;
    logic meas_wr_en = 1'b0;
    logic [3:0] meas_wr_index = 4'h0;
    logic [15:0] meas_wr_data = 16'h0000;
    logic [7:0] contrast_output_value;
    logic [15:0] ctl [7];
    logic [15:0] q [$];
    logic [15:0] rd [$];
    logic [15:0] r;
    int miscompares = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    paged_serial_register_port i_dut (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .sclk(sclk),
        .mosi(mosi),
        .ss_n(ss_n),
        .miso(miso),
        .miso_oe_n(miso_oe_n),
        .meas_wr_en(meas_wr_en),
        .meas_wr_index(meas_wr_index),
        .meas_wr_data(meas_wr_data),
        .contrast_output_value(contrast_output_value),
        .converter_control(ctl[0]),
        .keypad_scan_control(ctl[1]),
        .contrast_output_control(ctl[2]),
        .voltage_reference_control(ctl[3]),
        .software_reset_control(ctl[4]),
        .timing_configuration(ctl[5]),
        .keypad_key_mask(ctl[6])
    );

    spi_host_model i_host (
        .clk_sys(clk_sys),
        .sclk(sclk),
        .mosi(mosi),
        .ss_n(ss_n),
        .miso(miso)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one framed transfer: command, then n words taken from q (zero when q runs out)
    task automatic frame(input logic [15:0] cmd, input int n);
        rd = {};
        i_host.sel(1'b1);
        check("oe_n in frame", {15'h0000, miso_oe_n}, 16'h0000);
        i_host.shift(cmd, 16, r);
        for (int k = 0; k < n; k++)
        begin
            i_host.shift((k < q.size()) ? q[k] : 16'h0000, 16, r);
            rd.push_back(r);
        end
        i_host.sel(1'b0);
        check("oe_n idle", {15'h0000, miso_oe_n}, 16'h0001);
        q = {};
    endtask

    task automatic test_read_page0;
        for (int i = 0; i < 11; i++)
        begin
            meas_wr_en <= 1'b1;
            meas_wr_index <= i[3:0];
            meas_wr_data <= 16'h0A00 + i[15:0];
            @(posedge clk_sys);
        end
        meas_wr_en <= 1'b0;
        check("contrast reset", {8'h00, contrast_output_value}, 16'h007F);
        check("oe_n reset", {15'h0000, miso_oe_n}, 16'h0001);
        for (int i = 0; i < 7; i++)
            check("ctrl reset", ctl[i], 16'h0000);
        frame(16'h801F, 34);
        for (int k = 0; k < 34; k++)
            check("page0 word", rd[k], (k < 11) ? 16'h0A00 + k[15:0] : (k == 11) ? 16'h007F :
                (k == 16) ? 16'h0000 : 16'hFFFF);
    endtask

    task automatic test_write_ctrl;
        for (int i = 0; i < 7; i++)
            q.push_back(16'h1100 + i[15:0]);
        frame(16'h0800, 7);
        for (int i = 0; i < 6; i++)
            check("ctrl reg", ctl[i], 16'h1100 + i[15:0]);
        check("key mask kept", ctl[6], 16'h0000);
        q = {16'h1234};
        frame(16'h0A00, 1);
        check("key mask", ctl[6], 16'h1234);
        frame(16'h8800, 8);
        for (int k = 0; k < 8; k++)
            check("page1 word", rd[k], (k < 6) ? 16'h1100 + k[15:0] : 16'hFFFF);
    endtask

    task automatic test_dac_and_ro;
        q = {16'hAB55};
        frame(16'h0160, 1);
        check("contrast", {8'h00, contrast_output_value}, 16'h0055);
        q = {16'hDEAD};
        frame(16'h0000, 1);
        frame(16'h8160, 1);
        check("contrast read", rd[0], 16'h0055);
        // one frozen cycle: this measurement write must not land
        ce <= 1'b0;
        meas_wr_en <= 1'b1;
        meas_wr_index <= 4'h0;
        meas_wr_data <= 16'h5A5A;
        @(posedge clk_sys);
        meas_wr_en <= 1'b0;
        ce <= 1'b1;
        frame(16'h8000, 1);
        check("result kept", rd[0], 16'h0A00);
        q = {16'h4321};
        frame(16'h1000, 1);
        check("reserved page write", ctl[0], 16'h1100);
        frame(16'h9000, 2);
        check("reserved page read", rd[0] & rd[1], 16'hFFFF);
    endtask

    task automatic test_abort;
        i_host.sel(1'b1);
        i_host.shift(16'h0800, 16, r);
        i_host.shift(16'h5555, 8, r);
        i_host.sel(1'b0);
        // the rest of the cut word, unselected, must not complete it
        i_host.shift(16'h5555, 8, r);
        repeat (8) @(posedge clk_sys);
        check("aborted word", ctl[0], 16'h1100);
        q = {16'h2222};
        frame(16'h0800, 1);
        check("after abort", ctl[0], 16'h2222);
        i_host.shift(16'h0800, 16, r);
        i_host.shift(16'h3333, 16, r);
        repeat (8) @(posedge clk_sys);
        check("unselected bits", ctl[0], 16'h2222);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        test_read_page0();
        test_write_ctrl();
        test_dac_and_ro();
        test_abort();
        complete_run();
    end

    initial
    begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule
